//--- include/pwm_pkg.sv
// Constants, field layouts and bus carriers for the paired PWM timer
package pwm_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CH_N = 2;
    localparam int PRE_W = 11;
    localparam int SPRE_W = 4;
    localparam int CNT_W = 7;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DUTY_A = 8'h28;
    localparam logic [7:0] IDX_DUTY_B = 8'h29;
    localparam logic [7:0] IDX_MODE_A = 8'h2a;
    localparam logic [7:0] IDX_MODE_B = 8'h2b;
    localparam logic [7:0] IDX_PAIR = 8'h2c;
    localparam logic [7:0] IDX_STAT = 8'h2d;

    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_DUTY_A = 3'h1;
    localparam logic [2:0] SEL_MODE_A = 3'h3;
    localparam logic [2:0] SEL_PAIR = 3'h5;
    localparam logic [2:0] SEL_STAT = 3'h6;

    localparam logic [7:0] DUTY_RST = 8'hff;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [3:0] PAIR_RST = 4'h0;

    // Mode register fields
    localparam int MODE_TFF = 7;
    localparam int MODE_DBE = 6;
    localparam int MODE_CK_HI = 5;
    localparam int MODE_CK_LO = 3;
    localparam int MODE_EIN = 2;
    localparam int MODE_CM_HI = 1;
    localparam int MODE_CM_LO = 0;
    localparam logic [1:0] CM_PWM = 2'h2;
    // Duty register: extra-pulse enable in bit 0, duty in 7:1
    localparam int DUTY_AD = 0;
    // Channel pair control fields
    localparam int PAIR_RUN_A = 0;
    localparam int PAIR_CAS = 2;
    localparam int PAIR_AND = 3;

    localparam logic [CNT_W-1:0] CNT_MAX = 7'h7f;
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

    // Divider log2 per clock-select code, fast source; element 0 last
    localparam logic [7:0][3:0] FAST_LOG =
        {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hb};
    localparam logic [3:0] SLOW_LOG_0 = 4'h4;
    localparam logic [3:0] SLOW_LOG_1 = 4'h3;
    localparam logic [3:0] SLOW_LOG_7 = 4'h2;
    localparam logic [2:0] CK_0 = 3'h0;
    localparam logic [2:0] CK_1 = 3'h1;
    localparam logic [2:0] CK_7 = 3'h7;

    typedef enum logic [3:0] {
        PH_STOP = 4'b0001,
        PH_LEAD = 4'b0010,
        PH_EXTRA = 4'b0100,
        PH_TAIL = 4'b1000
    } phase_t;
endpackage

//--- core/pwm_pair.sv
// Two 7-bit PWM timer channels with extra pulse, APB register slave
`timescale 1ns/10ps
module pwm_pair
    import pwm_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // APB slave
    input wire pwm_pkg::apb_req_t apb_req,
    output pwm_pkg::apb_rsp_t apb_rsp,
    // Low-speed clock, one pulse per low-speed cycle
    input wire logic slow_tick,
    input wire logic divider_clock_select,
    input wire logic low_speed_mode,
    // Outputs
    output logic pulse_output_pin_a,
    output logic pulse_output_pin_b,
    output logic timer_interrupt_a,
    output logic timer_interrupt_b
);
    import pwm_pkg::*;

    logic [PRE_W-1:0] fast_pre;
    logic [SPRE_W-1:0] slow_pre;
    logic [7:0] duty_buf [CH_N];
    logic [7:0] duty_act [CH_N];
    logic [7:0] mode [CH_N];
    logic [3:0] pair;
    logic [CNT_W-1:0] cnt [CH_N];
    logic [CH_N-1:0] active;
    logic [CH_N-1:0] lvl;
    logic [CH_N-1:0] second;
    logic [CH_N-1:0] irq;
    logic setup;
    logic wr_en;
    logic [2:0] rsel;
    logic [DATA_W-1:0] rdata;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'h0, idx, 2'h0};
    endfunction

    function automatic logic [2:0] addr_sel(input logic [ADDR_W-1:0] a);
        if (a == byte_addr(IDX_DUTY_A))
            addr_sel = SEL_DUTY_A;
        else if (a == byte_addr(IDX_DUTY_B))
            addr_sel = SEL_DUTY_A + 3'h1;
        else if (a == byte_addr(IDX_MODE_A))
            addr_sel = SEL_MODE_A;
        else if (a == byte_addr(IDX_MODE_B))
            addr_sel = SEL_MODE_A + 3'h1;
        else if (a == byte_addr(IDX_PAIR))
            addr_sel = SEL_PAIR;
        else if (a == byte_addr(IDX_STAT))
            addr_sel = SEL_STAT;
        else
            addr_sel = SEL_NONE;
    endfunction

    function automatic logic pre_hit(input logic [PRE_W-1:0] p,
                                     input logic [3:0] l);
        logic [PRE_W-1:0] m;
        m = ~({PRE_W{1'b1}} << l);
        pre_hit = ((p & m) == m);
    endfunction

    // Source clock strobe for one channel's clock-select code
    function automatic logic src_tick(input logic [2:0] code,
                                      input logic [PRE_W-1:0] fp,
                                      input logic [SPRE_W-1:0] sp,
                                      input logic st,
                                      input logic dsel,
                                      input logic slow);
        logic [PRE_W-1:0] spx;
        spx = {{(PRE_W-SPRE_W){1'b0}}, sp};
        if (slow || (dsel && (code == CK_0 || code == CK_1)))
        begin
            if (code == CK_0)
                src_tick = st && pre_hit(spx, SLOW_LOG_0);
            else if (code == CK_1)
                src_tick = st && pre_hit(spx, SLOW_LOG_1);
            else if (code == CK_7)
                src_tick = st && pre_hit(spx, SLOW_LOG_7);
            else
                src_tick = 1'b0;
        end
        else
            src_tick = pre_hit(fp, FAST_LOG[code]);
    endfunction

    // Prescalers run free so channels share one divider chain
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            fast_pre <= '0;
            slow_pre <= '0;
        end
        else
        begin
            fast_pre <= fast_pre + 11'h001;
            if (slow_tick)
                slow_pre <= slow_pre + 4'h1;
        end
    end

    assign setup = apb_req.psel && !apb_req.penable;
    assign wr_en = apb_req.psel && apb_req.penable && apb_rsp.pready
                   && apb_req.pwrite;
    assign rsel = addr_sel(apb_req.paddr);

    always_comb
    begin
        rdata = '0;
        if (rsel == SEL_DUTY_A)
            rdata[7:0] = duty_buf[0];
        else if (rsel == SEL_DUTY_A + 3'h1)
            rdata[7:0] = duty_buf[1];
        else if (rsel == SEL_MODE_A)
            rdata[7:0] = mode[0];
        else if (rsel == SEL_MODE_A + 3'h1)
            rdata[7:0] = mode[1];
        else if (rsel == SEL_PAIR)
            rdata[3:0] = pair;
        else if (rsel == SEL_STAT)
        begin
            rdata[1:0] = active;
            rdata[3:2] = lvl;
            rdata[5:4] = second;
            rdata[14:8] = cnt[0];
            rdata[22:16] = cnt[1];
        end
    end

    // Read data is taken in the setup cycle; one access cycle, no waits
    always_ff @(posedge mclk)
    begin
        if (srst)
            apb_rsp <= '0;
        else
        begin
            apb_rsp.pready <= setup;
            if (setup)
            begin
                apb_rsp.prdata <= rdata;
                apb_rsp.pslverr <= (rsel == SEL_NONE);
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            pair <= PAIR_RST;
        else if (wr_en && rsel == SEL_PAIR)
            pair <= apb_req.pwdata[3:0];
    end

    genvar i;
    generate
        for (i = 0; i < CH_N; i = i + 1)
        begin : g_ch
            phase_t phase;
            logic tick;
            logic run;
            logic hit;
            logic ovf;
            logic wr_duty;

            assign run = pair[PAIR_RUN_A + i];
            assign tick = src_tick(mode[i][MODE_CK_HI:MODE_CK_LO],
                fast_pre, slow_pre, slow_tick, divider_clock_select,
                low_speed_mode);
            // Next-count compare keeps the edge on the tick grid; the
            // level compare still catches a duty written equal to count
            assign hit = (cnt[i] == duty_act[i][7:1])
                || (tick && (cnt[i] + CNT_ONE) == duty_act[i][7:1]);
            assign ovf = tick && (cnt[i] == CNT_MAX);
            assign wr_duty = wr_en && (rsel == SEL_DUTY_A + 3'(i));
            assign active[i] = run && !pair[PAIR_CAS]
                && mode[i][MODE_CM_HI:MODE_CM_LO] == CM_PWM
                && !mode[i][MODE_EIN];
            assign lvl[i] = mode[i][MODE_TFF] ^ (phase == PH_TAIL);

            always_ff @(posedge mclk)
            begin
                if (srst)
                    mode[i] <= MODE_RST;
                else if (wr_en && rsel == SEL_MODE_A + 3'(i) && !run)
                    mode[i] <= apb_req.pwdata[7:0];
            end

            always_ff @(posedge mclk)
            begin
                if (srst)
                begin
                    duty_buf[i] <= DUTY_RST;
                    duty_act[i] <= DUTY_RST;
                end
                else if (wr_duty)
                begin
                    duty_buf[i] <= apb_req.pwdata[7:0];
                    if (!(active[i] && mode[i][MODE_DBE]))
                        duty_act[i] <= apb_req.pwdata[7:0];
                end
                else if (active[i] && mode[i][MODE_DBE] && ovf
                         && second[i])
                    duty_act[i] <= duty_buf[i];
            end

            always_ff @(posedge mclk)
            begin
                if (srst)
                begin
                    phase <= PH_STOP;
                    cnt[i] <= '0;
                    second[i] <= 1'b0;
                    irq[i] <= 1'b0;
                end
                else if (!active[i])
                begin
                    phase <= PH_STOP;
                    cnt[i] <= '0;
                    second[i] <= 1'b0;
                    irq[i] <= 1'b0;
                end
                else
                begin
                    irq[i] <= ovf && second[i];
                    if (phase == PH_STOP)
                        phase <= PH_LEAD;
                    else if (ovf)
                    begin
                        cnt[i] <= '0;
                        phase <= PH_LEAD;
                        second[i] <= !second[i];
                    end
                    else
                    begin
                        if (tick)
                            cnt[i] <= cnt[i] + CNT_ONE;
                        case (phase)
                            PH_LEAD:
                            begin
                                // Below-count duty just waits for the wrap
                                if (hit && second[i] && duty_act[i][DUTY_AD])
                                    phase <= PH_EXTRA;
                                else if (hit)
                                    phase <= PH_TAIL;
                            end
                            PH_EXTRA:
                            begin
                                if (tick)
                                    phase <= PH_TAIL;
                            end
                            default:
                            begin
                                phase <= phase;
                            end
                        endcase
                    end
                end
            end
        end
    endgenerate

    // Pins are registered, so they trail the channel level by one cycle
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pulse_output_pin_a <= 1'b0;
            pulse_output_pin_b <= 1'b0;
            timer_interrupt_a <= 1'b0;
            timer_interrupt_b <= 1'b0;
        end
        else
        begin
            if (pair[PAIR_AND])
                pulse_output_pin_a <= lvl[0] & lvl[1];
            else
                pulse_output_pin_a <= lvl[0];
            pulse_output_pin_b <= lvl[1];
            timer_interrupt_a <= irq[0];
            timer_interrupt_b <= irq[1];
        end
    end
endmodule

//--- tb/pwm_pair_monitor.sv
// Port checks for the PWM timer pair
`timescale 1ns/10ps
module pwm_pair_monitor
    import pwm_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Bus and channel A outputs
    input wire pwm_pkg::apb_req_t apb_req,
    input wire pwm_pkg::apb_rsp_t apb_rsp,
    input wire logic pulse_output_pin_a,
    input wire logic timer_interrupt_a
);
    logic st;
    logic wr;
    logic ok;
    logic run;
    logic ab;
    logic tff;
    logic [1:0] idle;
    logic [8:0] gap;
    assign st = apb_req.psel && !apb_req.penable;
    assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready
        && apb_req.pwrite;
    assign ok = apb_req.paddr inside {[12'h0a0:12'h0b4]}
        && apb_req.paddr[1:0] == 2'h0;
    // Shadow of run, AND and level bits; mode ignored while running
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            run <= 1'b0;
            ab <= 1'b0;
            tff <= 1'b0;
        end
        else if (wr && apb_req.paddr == 12'h0b0)
        begin
            run <= apb_req.pwdata[0];
            ab <= apb_req.pwdata[3];
        end
        else if (wr && apb_req.paddr == 12'h0a8 && !run)
            tff <= apb_req.pwdata[7];
    end
    // Any write restarts the settle count, pins lag their cause
    always_ff @(posedge mclk)
    begin
        if (srst || run || wr)
            idle <= 2'h0;
        else if (idle != 2'h3)
            idle <= idle + 2'h1;
    end
    always_ff @(posedge mclk)
    begin
        if (srst)
            gap <= 9'h1ff;
        else if (timer_interrupt_a)
            gap <= 9'h000;
        else if (gap != 9'h1ff)
            gap <= gap + 9'h001;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    property p_rdy; st |=> apb_rsp.pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no pready after setup");
    property p_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    property p_bad;
        st && !ok |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000;
    endproperty
    a_bad: assert property (p_bad) else $error("unmapped not refused");
    property p_good; st && ok |=> !apb_rsp.pslverr; endproperty
    a_good: assert property (p_good) else $error("mapped access refused");
    property p_irq1; timer_interrupt_a |=> !timer_interrupt_a; endproperty
    a_irq1: assert property (p_irq1) else $error("irq not a pulse");
    property p_gap; timer_interrupt_a |-> gap >= 9'h0ff; endproperty
    a_gap: assert property (p_gap) else $error("irq on odd overflow");
    property p_lvl; idle == 2'h3 && !ab |-> pulse_output_pin_a == tff;
    endproperty
    a_lvl: assert property (p_lvl) else $error("stopped pin wrong");
    property p_quiet; idle == 2'h3 |-> !timer_interrupt_a; endproperty
    a_quiet: assert property (p_quiet) else $error("irq while stopped");
endmodule

bind pwm_pair pwm_pair_monitor u_mon
(
    .mclk(mclk),
    .srst(srst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .pulse_output_pin_a(pulse_output_pin_a),
    .timer_interrupt_a(timer_interrupt_a)
);

//--- tb/pwm_load.sv
// Load on a PWM pin, logs each low phase length in clock cycles
`timescale 1ns/10ps
module pwm_load
(
    // Clock and driven pin
    input wire logic mclk,
    input wire logic pin
);
    int low_len = 0;
    int runs[$];
    always @(posedge mclk)
    begin
        if (pin === 1'b0)
            low_len++;
        else if (low_len != 0)
        begin
            runs.push_back(low_len);
            low_len = 0;
        end
    end
endmodule

//--- tb/timer_pwm7_extra_pulse_tb_top.sv
// Self-checking bench for the PWM timer pair
`timescale 1ns/10ps
module timer_pwm7_extra_pulse_tb_top;
    import pwm_pkg::*;
    localparam logic [7:0] IDX_TAB [5] = '{IDX_DUTY_A, IDX_DUTY_B,
        IDX_MODE_A, IDX_MODE_B, IDX_PAIR};
    localparam logic [7:0] RST_TAB [5] = '{DUTY_RST, DUTY_RST, MODE_RST,
        MODE_RST, {4'h0, PAIR_RST}};
    logic mclk;
    logic srst;
    apb_req_t req;
    apb_rsp_t rsp;
    logic pin_a;
    logic irq_a;
    logic [31:0] rnd;
    logic [31:0] q;
    logic e;
    int n_errors = 0;
    int check_count = 0;

    pwm_pair dut
    (
        .mclk(mclk),
        .srst(srst),
        .apb_req(req),
        .apb_rsp(rsp),
        .slow_tick(1'b0),
        .divider_clock_select(1'b0),
        .low_speed_mode(1'b0),
        .pulse_output_pin_a(pin_a),
        .pulse_output_pin_b(),
        .timer_interrupt_a(irq_a),
        .timer_interrupt_b()
    );
    pwm_load u_load
    (
        .mclk(mclk),
        .pin(pin_a)
    );

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Low time of two periods; the level bit swaps which phase is low
    function automatic int low_sum(int d, int ad, int dv, logic t);
        return t ? 256 * dv - (2 * d + ad) * dv : (2 * d + ad) * dv;
    endfunction

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic apb(logic w, logic [7:0] idx, logic [31:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, {2'h0, idx, 2'h0}, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        @(posedge mclk);
        while (rsp.pready !== 1'b1 && n < 16)
        begin
            @(posedge mclk);
            n++;
        end
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge mclk);
        n_errors += (n >= 16);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        @(posedge mclk);
        while (irq_a !== 1'b1 && n < 3000)
        begin
            @(posedge mclk);
            n++;
        end
        n_errors += (n >= 3000);
    endtask

    // First logged run may be partial, so runs 1 and 2 form the pair
    task automatic measure(int s, int df);
        int n;
        int a;
        int b;
        wait_irq();
        u_load.runs.delete();
        n = 0;
        while (u_load.runs.size() < 3 && n < 4000)
        begin
            @(posedge mclk);
            n++;
        end
        a = u_load.runs[1];
        b = u_load.runs[2];
        chk("low sum", s, a + b);
        chk("low diff", df, a > b ? a - b : b - a);
    endtask

    initial
    begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        stop_test();
    end

    initial
    begin
        int d;
        int ad;
        int c;
        int dv;
        int n;
        logic [7:0] m;
        logic [31:0] v;
        srst = 1'b1;
        req = '0;
        rnd = 32'd79169;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        foreach (IDX_TAB[i])
        begin
            apb(1'b0, IDX_TAB[i], 32'h0);
            chk("reset val", {24'h0, RST_TAB[i]}, q);
        end
        apb(1'b0, 8'h2e, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        apb(1'b1, IDX_STAT, 32'hffff_ffff);
        chk("status err", 32'h0, {31'h0, e});
        for (int k = 0; k < 3; k++)
        begin
            c = 7 - k;
            dv = 1 << FAST_LOG[c];
            ad = k != 1;
            m = {k == 2, k == 1, c[2:0], 1'b0, CM_PWM};
            apb(1'b1, IDX_MODE_A, {24'h0, m});
            for (int p = 0; p < 2; p++)
            begin
                rnd = lfsr(rnd);
                d = 8 + rnd % 100;
                v = {24'h0, d[6:0], ad[0]};
                apb(1'b1, IDX_DUTY_A, v);
                apb(1'b0, IDX_DUTY_A, 32'h0);
                chk("duty read", v, q);
                if (p == 0)
                    apb(1'b1, IDX_PAIR, 32'h1);
                wait_irq();
                measure(low_sum(d, ad, dv, m[7]), ad * dv);
            end
            apb(1'b1, IDX_MODE_A, 32'h0);
            apb(1'b0, IDX_MODE_A, 32'h0);
            chk("mode lock", {24'h0, m}, q);
            n = 0;
            repeat (1024 * dv)
            begin
                @(posedge mclk);
                n += (irq_a === 1'b1);
            end
            chk("irq count", 32'h4, n);
            apb(1'b1, IDX_PAIR, 32'h0);
            repeat (3) @(posedge mclk);
            chk("stop pin", {31'h0, m[7]}, {31'h0, pin_a});
        end
        apb(1'b1, IDX_PAIR, 32'h0000_0008);
        for (int j = 0; j < 2; j++)
        begin
            apb(1'b1, IDX_MODE_B, {24'h0, j[0], 7'h02});
            repeat (3) @(posedge mclk);
            chk("and pin", {31'h0, j[0]}, {31'h0, pin_a});
        end
        stop_test();
    end
endmodule
